//--- oad_pkg.sv
// Shared types and constants for the operand address decoder, plus its address adder.
package oad_pkg;

   // Addressing-form field codes.
   localparam logic [1:0] FORM_NO_DISP = 2'b00;
   localparam logic [1:0] FORM_DISP8   = 2'b01;
   localparam logic [1:0] FORM_DISP16  = 2'b10;
   localparam logic [1:0] FORM_REG     = 2'b11;

   // Register-select codes with a special meaning.
   localparam logic [2:0] RM_PTR_SRC = 3'h2;
   localparam logic [2:0] RM_PTR_DST = 3'h3;
   localparam logic [2:0] RM_BASE_PT = 3'h6;

   // Prefix and opcode patterns.
   localparam logic [2:0] SEG_PFX_HI  = 3'h1;
   localparam logic [2:0] SEG_PFX_LO  = 3'h6;
   localparam logic [7:0] OPC_PROT    = 8'h0F;
   localparam logic [7:0] SEC_DESC    = 8'h01;
   localparam logic [7:0] SEC_MODRM_MAX = 8'h03;

   // Field positions inside the addressing byte.
   localparam int FORM_POS = 6;
   localparam int OP2_POS  = 3;
   localparam int RM_POS   = 0;

   // Reset values.
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [7:0]  ZERO_BYTE = 8'h00;

   // Immediate kinds.
   localparam logic [1:0] IMM_NONE = 2'h0;
   localparam logic [1:0] IMM_BYTE = 2'h1;
   localparam logic [1:0] IMM_WORD = 2'h2;
   localparam logic [1:0] IMM_SEXT = 2'h3;

   typedef enum logic [4:0] {
      acc_word   = 5'h00, count_word = 5'h01, data_word = 5'h02, base_word = 5'h03,
      stack_ptr  = 5'h04, base_ptr   = 5'h05, src_index = 5'h06, dst_index = 5'h07,
      acc_lo     = 5'h08, count_lo   = 5'h09, data_lo   = 5'h0A, base_lo   = 5'h0B,
      acc_hi     = 5'h0C, count_hi   = 5'h0D, data_hi   = 5'h0E, base_hi   = 5'h0F
   } oad_reg_t;

   typedef enum logic [1:0] {
      extra_seg = 2'h0, code_seg = 2'h1, stack_seg = 2'h2, data_seg = 2'h3
   } oad_seg_t;

   // Current address register values from the register file.
   typedef struct packed {
      logic [15:0] base_word;
      logic [15:0] base_ptr;
      logic [15:0] src_index;
      logic [15:0] dst_index;
   } oad_regs_t;

   // One decoded instruction as handed to the execution and address units.
   typedef struct packed {
      logic [7:0]  opcode;
      logic [7:0]  secondary;
      logic        protected_mode;
      logic        desc_table;
      logic        has_modrm;
      logic [1:0]  form;
      logic [2:0]  operand_two;
      logic [2:0]  reg_select;
      logic [2:0]  ext_op;
      oad_reg_t    reg_operand;
      logic        mem_access;
      oad_reg_t    rm_operand;
      logic [15:0] displacement;
      logic [15:0] operand_address;
      oad_seg_t    mem_seg;
      oad_seg_t    string_dst_seg;
      logic        seg_override;
      logic [1:0]  imm_kind;
      logic [15:0] immediate;
   } oad_result_t;

endpackage

`timescale 1ns/10ps
// Effective address adder: base plus index plus displacement, by addressing form.
module oad_addr_calc (
   input  wire logic [1:0]        form,
   input  wire logic [2:0]        reg_select,
   input  wire logic [15:0]       displacement,
   input  oad_pkg::oad_regs_t     regs,
   output logic [15:0]            address,
   output logic                   uses_base_ptr
);
   import oad_pkg::*;

   logic        direct;
   logic [15:0] base;
   logic [15:0] index;

   // The direct form has no base at all; the displacement is the address.
   assign direct = (form == FORM_NO_DISP) && (reg_select == RM_BASE_PT);  // [RULE9]

   // Base term per register-select code.
   assign base = (reg_select[2:1] == 2'h0)          ? regs.base_word :    // [RULE6]
                 (reg_select[2:1] == 2'h1)          ? regs.base_ptr  :    // [RULE6]
                 (reg_select == 3'h7)               ? regs.base_word :    // [RULE7]
                 (reg_select == RM_BASE_PT && !direct) ? regs.base_ptr :  // [RULE8]
                 ZERO_WORD;

   // Index term: source index on even codes, destination index on odd, for codes 0..5.
   assign index = (reg_select[2:1] == 2'h3) ? ZERO_WORD :
                  reg_select[0] ? regs.dst_index : regs.src_index;        // [RULE6] [RULE7]

   assign address = base + index + displacement;
   assign uses_base_ptr = (reg_select == RM_PTR_SRC) || (reg_select == RM_PTR_DST) ||
                          ((reg_select == RM_BASE_PT) && !direct);
endmodule

//--- oad_decoder.sv
// Operand address decoder: parses prefix, opcode, addressing byte, displacement and immediate.
//
// Behaviour
// [RULE1] Addressing byte follows opcode; split three fields.
// [RULE2] Form 11: register operand, no memory access.
// [RULE3] Form 00: zero displacement, no displacement bytes.
// [RULE4] Form 01: one byte, sign-extended displacement.
// [RULE5] Form 10: two bytes, low then high.
// [RULE6] Codes 000-011: base plus index plus displacement.
// [RULE7] Codes 100,101,111: single register plus displacement.
// [RULE8] Code 110, nonzero form: base_ptr plus displacement.
// [RULE9] Form 00 code 110: two-byte direct address.
// [RULE10] Displacement precedes any immediate data bytes.
// [RULE11] Prefix 001ss110 selects segment override.
// [RULE12] Size flag picks word or byte register.
// [RULE13] base_ptr addressing defaults to stack_seg.
// [RULE14] String destination always extra_seg, no override.
// [RULE15] Byte after protected escape is secondary opcode.
// [RULE16] Sign-extending immediate: one byte widened.
// [RULE17] Group opcodes use operand-two as extension.
// [RULE18] Descriptor table group: 0F, 01, addressing byte.
`timescale 1ns/10ps
module oad_decoder (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             byte_valid,
   input  wire logic [7:0]       byte_data,
   output logic                  byte_ready,
   input  oad_pkg::oad_regs_t    regs,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output oad_pkg::oad_result_t  result
);
   import oad_pkg::*;

   typedef enum logic [2:0] {
      ST_OPC     = 3'h0,
      ST_SEC     = 3'h1,
      ST_MODRM   = 3'h2,
      ST_DISP_LO = 3'h3,
      ST_DISP_HI = 3'h4,
      ST_IMM_LO  = 3'h5,
      ST_IMM_HI  = 3'h6,
      ST_CALC    = 3'h7
   } oad_state_t;

   // One extra flag marks the hand-over cycle so the state code stays three bits.
   oad_state_t  state_reg;
   oad_state_t  state_next;
   logic        done_reg;
   logic [7:0]  opcode_reg;
   logic [7:0]  sec_reg;
   logic        prot_reg;
   logic [7:0]  modrm_reg;
   logic        has_modrm_reg;
   logic [15:0] disp_reg;
   logic [15:0] imm_reg;
   logic [1:0]  imm_kind_reg;
   oad_seg_t    ovr_seg_reg;
   logic        ovr_valid_reg;
   oad_result_t result_reg;

   // Maps a 3-bit operand field and the size flag onto a register name.
   function automatic oad_reg_t reg_decode(input logic [2:0] field, input logic word);
      reg_decode = oad_reg_t'({1'b0, ~word, field});             // [RULE12]
   endfunction

   // True for one-byte opcodes that carry an addressing byte.
   function automatic logic needs_modrm(input logic [7:0] op);
      needs_modrm = ((op[7:6] == 2'h0) && (op[2] == 1'b0)) ||
                    (op == 8'h62) || (op == 8'h63) || (op == 8'h69) || (op == 8'h6B) ||
                    (op[7:4] == 4'h8) || (op[7:1] == 7'h60) || (op[7:2] == 6'h31) ||
                    (op[7:3] == 5'h1B) || (op[7:1] == 7'h7B) || (op[7:1] == 7'h7F) ||
                    (op == 8'hC4) || (op == 8'hC5) || (op[7:1] == 7'h63);
   endfunction

   // Immediate size that an opcode carries; ext is the operand-two field when known.
   function automatic logic [1:0] imm_kind_of(input logic [7:0] op, input logic [2:0] ext);
      if ((op[7:6] == 2'h0) && (op[2:1] == 2'h2)) begin
         imm_kind_of = op[0] ? IMM_WORD : IMM_BYTE;
      end else if ((op == 8'h80) || (op == 8'h82) || (op == 8'hC6) || (op[7:1] == 7'h60)) begin
         imm_kind_of = IMM_BYTE;
      end else if ((op == 8'h81) || (op == 8'hC7) || (op == 8'h69) || (op == 8'h68)) begin
         imm_kind_of = IMM_WORD;
      end else if ((op == 8'h83) || (op == 8'h6B) || (op == 8'h6A)) begin
         imm_kind_of = IMM_SEXT;                                  // [RULE16]
      end else if ((op == 8'hA8) || (op[7:3] == 5'h16)) begin
         imm_kind_of = IMM_BYTE;
      end else if ((op == 8'hA9) || (op[7:3] == 5'h17)) begin
         imm_kind_of = IMM_WORD;
      end else if ((op[7:1] == 7'h7B) && (ext == 3'h0)) begin
         imm_kind_of = op[0] ? IMM_WORD : IMM_BYTE;
      end else begin
         imm_kind_of = IMM_NONE;
      end
   endfunction

   // Handshake and byte decode.
   logic       take;
   logic       is_seg_pfx;
   logic [1:0] form_in;
   logic [2:0] rm_in;
   logic [1:0] disp_len_in;
   logic [1:0] imm_after_op;
   logic [1:0] imm_after_modrm;
   logic [1:0] imm_pending;

   assign byte_ready = !done_reg && (state_reg != ST_CALC);
   assign take = byte_valid && byte_ready;
   assign is_seg_pfx = (byte_data[7:5] == SEG_PFX_HI) && (byte_data[2:0] == SEG_PFX_LO);  // [RULE11]
   assign form_in = byte_data[FORM_POS +: 2];                   // [RULE1]
   assign rm_in = byte_data[RM_POS +: 3];                       // [RULE1]

   // Displacement byte count taken from the addressing byte as it arrives.
   assign disp_len_in = (form_in == FORM_DISP8)  ? 2'h1 :       // [RULE4]
                        (form_in == FORM_DISP16) ? 2'h2 :       // [RULE5]
                        ((form_in == FORM_NO_DISP) && (rm_in == RM_BASE_PT)) ? 2'h2 :  // [RULE9]
                        2'h0;                                   // [RULE2] [RULE3]

   assign imm_after_op = imm_kind_of(byte_data, 3'h0);
   assign imm_after_modrm = prot_reg ? IMM_NONE : imm_kind_of(opcode_reg, byte_data[OP2_POS +: 3]);
   assign imm_pending = imm_kind_reg;

   // Next-state logic over the instruction byte stream.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OPC: begin
            if (take && !is_seg_pfx) begin
               if (byte_data == OPC_PROT) begin
                  state_next = ST_SEC;                          // [RULE15]
               end else if (needs_modrm(byte_data)) begin
                  state_next = ST_MODRM;                        // [RULE1]
               end else if (imm_after_op != IMM_NONE) begin
                  state_next = ST_IMM_LO;
               end else begin
                  state_next = ST_CALC;
               end
            end
         end
         ST_SEC: begin
            if (take) begin
               state_next = (byte_data <= SEC_MODRM_MAX) ? ST_MODRM : ST_CALC;   // [RULE18]
            end
         end
         ST_MODRM: begin
            if (take) begin
               if (disp_len_in != 2'h0) begin
                  state_next = ST_DISP_LO;                      // [RULE10]
               end else if (imm_after_modrm != IMM_NONE) begin
                  state_next = ST_IMM_LO;
               end else begin
                  state_next = ST_CALC;
               end
            end
         end
         ST_DISP_LO: begin
            if (take) begin
               if ((modrm_reg[FORM_POS +: 2] != FORM_DISP8)) begin
                  state_next = ST_DISP_HI;                      // [RULE5] [RULE9]
               end else if (imm_pending != IMM_NONE) begin
                  state_next = ST_IMM_LO;                       // [RULE10]
               end else begin
                  state_next = ST_CALC;
               end
            end
         end
         ST_DISP_HI: begin
            if (take) begin
               state_next = (imm_pending != IMM_NONE) ? ST_IMM_LO : ST_CALC;   // [RULE10]
            end
         end
         ST_IMM_LO: begin
            if (take) begin
               state_next = (imm_pending == IMM_WORD) ? ST_IMM_HI : ST_CALC;   // [RULE16]
            end
         end
         ST_IMM_HI: begin
            if (take) begin
               state_next = ST_CALC;
            end
         end
         ST_CALC: begin
            state_next = ST_OPC;
         end
         default: begin
            state_next = ST_OPC;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_OPC;
      end else if (!done_reg) begin
         state_reg <= state_next;
      end
   end

   // Output valid holds from the calculation until the consumer takes it.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         done_reg <= 1'b0;
      end else if (state_reg == ST_CALC) begin
         done_reg <= 1'b1;
      end else if (out_ready) begin
         done_reg <= 1'b0;
      end
   end

   // Segment override prefix capture; it lives until the instruction is handed over.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ovr_valid_reg <= 1'b0;
         ovr_seg_reg   <= data_seg;
      end else if (take && (state_reg == ST_OPC) && is_seg_pfx) begin
         ovr_valid_reg <= 1'b1;                                 // [RULE11]
         ovr_seg_reg   <= oad_seg_t'(byte_data[4:3]);           // [RULE11]
      end else if (done_reg && out_ready) begin
         ovr_valid_reg <= 1'b0;
      end
   end

   // Opcode, secondary opcode and addressing byte capture.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         opcode_reg    <= ZERO_BYTE;
         sec_reg       <= ZERO_BYTE;
         prot_reg      <= 1'b0;
         modrm_reg     <= ZERO_BYTE;
         has_modrm_reg <= 1'b0;
         imm_kind_reg  <= IMM_NONE;
      end else if (take) begin
         if ((state_reg == ST_OPC) && !is_seg_pfx) begin
            opcode_reg    <= byte_data;
            sec_reg       <= ZERO_BYTE;
            prot_reg      <= (byte_data == OPC_PROT);           // [RULE15]
            modrm_reg     <= ZERO_BYTE;
            has_modrm_reg <= 1'b0;
            imm_kind_reg  <= imm_after_op;
         end else if (state_reg == ST_SEC) begin
            sec_reg <= byte_data;                               // [RULE15]
         end else if (state_reg == ST_MODRM) begin
            modrm_reg     <= byte_data;                         // [RULE1]
            has_modrm_reg <= 1'b1;
            imm_kind_reg  <= imm_after_modrm;
         end
      end
   end

   // Displacement and immediate assembly, low byte first.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         disp_reg <= ZERO_WORD;
         imm_reg  <= ZERO_WORD;
      end else if (take) begin
         if (state_reg == ST_OPC) begin
            disp_reg <= ZERO_WORD;                              // [RULE3]
            imm_reg  <= ZERO_WORD;
         end else if (state_reg == ST_DISP_LO) begin
            disp_reg <= {{8{byte_data[7]}}, byte_data};         // [RULE4]
         end else if (state_reg == ST_DISP_HI) begin
            disp_reg[15:8] <= byte_data;                        // [RULE5] [RULE9]
         end else if (state_reg == ST_IMM_LO) begin
            imm_reg <= (imm_pending == IMM_SEXT) ? {{8{byte_data[7]}}, byte_data} :  // [RULE16]
                       {8'h00, byte_data};
         end else if (state_reg == ST_IMM_HI) begin
            imm_reg[15:8] <= byte_data;
         end
      end
   end

   // Field split and address arithmetic on the captured bytes.
   logic [1:0]  form_w;
   logic [2:0]  op2_w;
   logic [2:0]  rm_w;
   logic        word_w;
   logic        reg_form_w;
   logic [15:0] address_w;
   logic        uses_ptr_w;
   logic        string_op_w;
   oad_seg_t    mem_seg_w;

   assign form_w = modrm_reg[FORM_POS +: 2];                    // [RULE1]
   assign op2_w  = modrm_reg[OP2_POS +: 3];                     // [RULE1] [RULE17]
   assign rm_w   = modrm_reg[RM_POS +: 3];                      // [RULE1]
   assign word_w = prot_reg ? 1'b1 : opcode_reg[0];
   assign reg_form_w = has_modrm_reg && (form_w == FORM_REG);   // [RULE2]

   oad_addr_calc oad_addr_calc_inst (
      .form          (form_w),
      .reg_select    (rm_w),
      .displacement  (disp_reg),
      .regs          (regs),
      .address       (address_w),
      .uses_base_ptr (uses_ptr_w)
   );

   // String primitives whose destination goes through dst_index.
   assign string_op_w = !prot_reg && ((opcode_reg[7:4] == 4'hA) && (opcode_reg[3:0] >= 4'h4) &&
                        (opcode_reg[3:1] != 3'h4) && (opcode_reg[3:1] != 3'h6) ||
                        (opcode_reg[7:1] == 7'h36));

   // An override wins over the defaults; base_ptr forms fall back to the stack segment.
   assign mem_seg_w = ovr_valid_reg ? ovr_seg_reg :
                      uses_ptr_w    ? stack_seg : data_seg;     // [RULE13]

   // Result capture in the calculation cycle; data outputs come from this register.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         result_reg <= '0;
      end else if (state_reg == ST_CALC) begin
         result_reg.opcode          <= opcode_reg;
         result_reg.secondary       <= sec_reg;
         result_reg.protected_mode  <= prot_reg;                // [RULE15]
         result_reg.desc_table      <= prot_reg && (sec_reg == SEC_DESC);   // [RULE18]
         result_reg.has_modrm       <= has_modrm_reg;
         result_reg.form            <= form_w;
         result_reg.operand_two     <= op2_w;
         result_reg.reg_select      <= rm_w;
         result_reg.ext_op          <= op2_w;                   // [RULE17]
         result_reg.reg_operand     <= reg_decode(op2_w, word_w);   // [RULE12]
         result_reg.mem_access      <= has_modrm_reg && !reg_form_w;  // [RULE2]
         result_reg.rm_operand      <= reg_decode(rm_w, word_w);    // [RULE2] [RULE12]
         result_reg.displacement    <= disp_reg;
         result_reg.operand_address <= reg_form_w ? ZERO_WORD : address_w;
         result_reg.mem_seg         <= mem_seg_w;
         result_reg.string_dst_seg  <= extra_seg;               // [RULE14]
         result_reg.seg_override    <= ovr_valid_reg;
         result_reg.imm_kind        <= imm_kind_reg;
         result_reg.immediate       <= imm_reg;
      end
   end

   // The string flag only affects which segment the consumer must pair with dst_index.
   logic string_dst_reg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         string_dst_reg <= 1'b0;
      end else if (state_reg == ST_CALC) begin
         string_dst_reg <= string_op_w;                         // [RULE14]
      end
   end

   // For string destinations the override is masked so nobody can apply it there.
   always_comb begin
      result = result_reg;
      if (string_dst_reg) begin
         result.string_dst_seg = extra_seg;                     // [RULE14]
      end
   end

   assign out_valid = done_reg;
endmodule

//--- oad_decoder_asserts.sv
// Port checks for the operand address decoder.
`timescale 1ns/10ps
module oad_decoder_asserts
   import oad_pkg::*;
(
   input wire logic                 clock,
   input wire logic                 rstn,
   input wire logic                 byte_valid,
   input wire logic [7:0]           byte_data,
   input wire logic                 byte_ready,
   input wire oad_pkg::oad_regs_t   regs,
   input wire logic                 out_valid,
   input wire logic                 out_ready,
   input wire oad_pkg::oad_result_t result
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // A result whose addressing byte names memory.
   wire mem_f = out_valid && result.has_modrm && result.form != FORM_REG;
   // The forms that lean on base_ptr.
   wire ptr_f = result.reg_select == RM_PTR_SRC || result.reg_select == RM_PTR_DST ||
      (result.reg_select == RM_BASE_PT && result.form != FORM_NO_DISP);
   sequence s_offer; out_valid && !out_ready; endsequence
   sequence s_hold; out_valid && $stable(result); endsequence
   sequence s_take; out_valid && out_ready; endsequence
   property p_hold; s_offer |=> s_hold; endproperty
   a_hold: assert property (p_hold) else $error("result moved before handover");
   property p_release; s_take |=> !out_valid && byte_ready; endproperty
   a_release: assert property (p_release) else $error("handover did not free the input");
   property p_refuse; out_valid |-> !byte_ready; endproperty
   a_refuse: assert property (p_refuse) else $error("byte accepted while result pending");
   property p_reg; out_valid && result.has_modrm && result.form == FORM_REG |->
      !result.mem_access && result.operand_address == ZERO_WORD; endproperty
   a_reg: assert property (p_reg) else $error("register form touched memory");
   property p_zero; mem_f && result.form == FORM_NO_DISP && result.reg_select != RM_BASE_PT |->
      result.displacement == ZERO_WORD; endproperty
   a_zero: assert property (p_zero) else $error("nonzero displacement in form 00");
   property p_sext; mem_f && result.form == FORM_DISP8 |->
      result.displacement[15:8] == {8{result.displacement[7]}}; endproperty
   a_sext: assert property (p_sext) else $error("short displacement not sign extended");
   property p_pair; $rose(out_valid) && mem_f && result.reg_select == 3'h0 |->
      result.operand_address == 16'($past(regs.base_word) + $past(regs.src_index) + result.displacement);
   endproperty
   a_pair: assert property (p_pair) else $error("base plus index address wrong");
   property p_ptr; mem_f && !result.seg_override && ptr_f |-> result.mem_seg == stack_seg; endproperty
   a_ptr: assert property (p_ptr) else $error("base_ptr form not on stack segment");
   property p_dst; out_valid |-> result.string_dst_seg == extra_seg; endproperty
   a_dst: assert property (p_dst) else $error("string destination not extra segment");
   property p_size; out_valid && result.has_modrm && result.form == FORM_REG && !result.protected_mode |->
      result.rm_operand == oad_reg_t'({1'b0, !result.opcode[0], result.reg_select}); endproperty
   a_size: assert property (p_size) else $error("register operand size wrong");
endmodule

bind oad_decoder oad_decoder_asserts oad_decoder_asserts_inst (.clock(clock), .rstn(rstn),
   .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready), .regs(regs),
   .out_valid(out_valid), .out_ready(out_ready), .result(result));

//--- oad_prefetch_model.sv
// Behavioural prefetch queue offering instruction bytes.
`timescale 1ns/10ps
module oad_prefetch_model (
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       slow,
   input  wire logic       byte_ready,
   output logic            byte_valid,
   output logic [7:0]      byte_data
);
   logic [7:0] q[$];
   logic       taken;
   // Bytes leave in the order pushed.
   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask
   initial begin
      byte_valid = 1'b0;
      byte_data = 8'h5A;
   end
   // Moves just after each edge; slow mode leaves a gap after each byte.
   // An idle line shows the inverse of the last byte so stale data is never mistaken.
   always @(posedge clock) begin
      taken = byte_valid && byte_ready && rstn;
      #1;
      if (taken)
         void'(q.pop_front());
      if (rstn && q.size() > 0 && !(slow && taken)) begin
         byte_valid = 1'b1;
         byte_data = q[0];
      end else begin
         if (byte_valid)
            byte_data = ~byte_data;
         byte_valid = 1'b0;
      end
   end
endmodule

//--- oad_decoder_tb.sv
// Self-checking bench for the operand address decoder.
`timescale 1ns/10ps
module oad_decoder_tb;
   import oad_pkg::*;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic        slow = 1'b0;
   logic        out_ready = 1'b0;
   oad_regs_t   regs = {16'h0100, 16'h1000, 16'h0020, 16'h0003};
   logic        byte_valid;
   logic        byte_ready;
   logic        out_valid;
   logic [7:0]  byte_data;
   oad_result_t result;
   int          failures = 0;
   int          checks = 0;
   always #5 clock = ~clock;
   oad_decoder oad_decoder_inst (.clock(clock), .rstn(rstn), .byte_valid(byte_valid),
      .byte_data(byte_data), .byte_ready(byte_ready), .regs(regs), .out_valid(out_valid),
      .out_ready(out_ready), .result(result));
   oad_prefetch_model oad_prefetch_model_inst (.clock(clock), .rstn(rstn), .slow(slow),
      .byte_ready(byte_ready), .byte_valid(byte_valid), .byte_data(byte_data));
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Queues one instruction and waits, with a bound, for its result.
   task automatic ins(input logic [7:0] b[$]);
      int n = 0;
      foreach (b[i])
         oad_prefetch_model_inst.push(b[i]);
      while (out_valid !== 1'b1 && n < 100) begin
         @(posedge clock);
         #1;
         n++;
      end
      cmp("out_valid", 16'h1, {15'h0, out_valid});
   endtask
   // Hands the result over across one edge.
   task automatic take();
      out_ready = 1'b1;
      @(posedge clock);
      #1;
      out_ready = 1'b0;
   endtask
   task automatic t_basic();
      ins('{8'h8B, 8'h46, 8'hFE});
      cmp("form", 16'h1, 16'(result.form));
      cmp("disp", 16'hFFFE, result.displacement);
      cmp("addr", 16'h0FFE, result.operand_address);
      cmp("seg", 16'(stack_seg), 16'(result.mem_seg));
      cmp("reg", 16'(acc_word), 16'(result.reg_operand));
      take();
   endtask
   // Every register-select code with a two-byte displacement, stalled feed.
   task automatic t_forms();
      logic [15:0] tab[8] = '{16'h1354, 16'h1337, 16'h2254, 16'h2237, 16'h1254, 16'h1237, 16'h2234, 16'h1334};
      slow = 1'b1;
      for (int r = 0; r < 8; r++) begin
         ins('{8'h8B, {5'b10010, 3'(r)}, 8'h34, 8'h12});
         cmp("addr", tab[r], result.operand_address);
         cmp("reg", 16'(data_word), 16'(result.reg_operand));
         take();
      end
      slow = 1'b0;
   endtask
   task automatic t_direct();
      ins('{8'h8A, 8'h0E, 8'h78, 8'h56});
      cmp("addr", 16'h5678, result.operand_address);
      cmp("seg", 16'(data_seg), 16'(result.mem_seg));
      cmp("reg", 16'(count_lo), 16'(result.reg_operand));
      take();
      ins('{8'h8B, 8'h07});
      cmp("addr", 16'h0100, result.operand_address);
      take();
      ins('{8'h8B, 8'hC3});
      cmp("mem", 16'h0, 16'(result.mem_access));
      cmp("rm", 16'(base_word), 16'(result.rm_operand));
      take();
      ins('{8'h8A, 8'hC7});
      cmp("rm", 16'(base_hi), 16'(result.rm_operand));
      take();
   endtask
   // Each override code, then a plain access to see the override gone.
   task automatic t_override();
      for (int s = 0; s < 4; s++) begin
         ins('{{3'b001, 2'(s), 3'b110}, 8'h8B, 8'h46, 8'h02});
         cmp("seg", 16'(s), 16'(result.mem_seg));
         cmp("ovr", 16'h1, 16'(result.seg_override));
         cmp("dst", 16'(extra_seg), 16'(result.string_dst_seg));
         take();
      end
      ins('{8'h8B, 8'h46, 8'h02});
      cmp("seg", 16'(stack_seg), 16'(result.mem_seg));
      take();
   endtask
   task automatic t_imm();
      for (int e = 0; e < 8; e++) begin
         ins('{8'h83, {2'b01, 3'(e), 3'h6}, 8'h02, 8'hF0});
         cmp("ext", 16'(e), 16'(result.ext_op));
         cmp("disp", 16'h0002, result.displacement);
         cmp("imm", 16'hFFF0, result.immediate);
         cmp("kind", 16'(IMM_SEXT), 16'(result.imm_kind));
         take();
      end
      ins('{8'h81, 8'h86, 8'h00, 8'h01, 8'h34, 8'h12});
      cmp("addr", 16'h1100, result.operand_address);
      cmp("imm", 16'h1234, result.immediate);
      take();
   endtask
   task automatic t_prot();
      ins('{8'h0F, 8'h01, 8'h16, 8'h34, 8'h12});
      cmp("prot", 16'h1, 16'(result.protected_mode));
      cmp("sec", 16'h0001, 16'(result.secondary));
      cmp("desc", 16'h1, 16'(result.desc_table));
      cmp("op2", 16'h2, 16'(result.operand_two));
      cmp("addr", 16'h1234, result.operand_address);
      take();
      ins('{8'h0F, 8'h06});
      cmp("modrm", 16'h0, 16'(result.has_modrm));
      take();
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // A hung handshake is cut off well past the few hundred cycles needed.
   initial begin
      #100us;
      failures++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge clock);
      #1;
      rstn = 1'b1;
      t_basic();
      t_forms();
      t_direct();
      t_override();
      t_imm();
      t_prot();
      report_and_stop();
   end
endmodule
